// ---- core/idacu_chan.sv ----
// one current dac channel: update source select, justification and input latch
// assumes events and write pulses come from logic on sys_clk_i
`timescale 1ns/10ps
`include "idacu_regs.svh"
module idacu_chan (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  idacu_chan_if.chan ch
);
  idacu_pkg::idacu_chan_st_t st;
  idacu_pkg::idacu_chan_st_t nxt;
  idacu_pkg::idacu_src_t src;
  logic sel;
  logic [11:0] word;

  assign src = idacu_pkg::idacu_src_t'(ch.ctrl[`IDACU_SRC_HI:`IDACU_SRC_LO]);
  assign sel = ch.evt[src];
  // right: hi[3:0] then the whole low byte; left: whole high byte then lo[7:4]
  assign word = ch.ctrl[`IDACU_RJ_BIT] ? {ch.hi[3:0], ch.lo} : {ch.hi, ch.lo[7:4]};

  always_comb begin
    nxt = st;
    // only the selected event moves the latch, data writes never do
    if (sel) begin
      nxt.code = word;
    end
    // a write in the same cycle as the event stays pending for the next one
    nxt.pend = (st.pend & ~sel) | ch.wr_data;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign ch.code = st.code;
  assign ch.pend = st.pend;

  AST_CHAN_LATCH: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    sel |=> ch.code == $past(word))
    else $error("input latch missed its update event");
  AST_CHAN_HOLD: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !sel |=> $stable(ch.code))
    else $error("input latch changed without an event");
  AST_CHAN_RJ: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (sel && ch.ctrl[`IDACU_RJ_BIT]) |=> ch.code == {$past(ch.hi[3:0]), $past(ch.lo)})
    else $error("right justified word mapped wrongly");
endmodule

// ---- core/idacu_top.sv ----
// dual current dac update control: register file, update events, routing and bias request
// assumes a one-cycle-read sfr port on sys_clk_i and timer overflow pulses on the same clock
//
// Contract
// - each dac offers four full-scale settings, 0.25 to 2 mA
// - each dac is enabled by the enable bit of its own control register
// - with both enabled, outputs go to separate pins or one, per merge select
// - bias generator request is high while at least one dac is enabled
// - update source sits at control bits 6:4 and resets to on-demand 111
// - on-demand: a low byte write is held until the next high byte write
// - on-demand: a high byte write copies both bytes into the input latch
// - source codes 000 to 011 update on timer 0 to 3 overflow
// - timers 2 and 3 use low overflow in 8-bit mode, high in 16-bit
// - codes 100, 101, 110 update on rising, falling or either strobe edge
// - on the chosen strobe edge both held bytes go to the input latch
// - left: d11-d4 in high, d3-d0 in low 7:4; right: d11-d8 high 3:0
// - justify select at control bit 2, full-scale select at bits 1:0
// - full-scale codes 00 to 11 select 0.25, 0.5, 1 and 2 mA
// - both enabled and merge select 1 puts both outputs on the first pin
`timescale 1ns/10ps
`include "idacu_regs.svh"
module idacu_top (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic t0_ovf_i,
  input wire logic t1_ovf_i,
  input wire logic t2_low_ovf_i,
  input wire logic t2_high_ovf_i,
  input wire logic t2_mode16_i,
  input wire logic t3_low_ovf_i,
  input wire logic t3_high_ovf_i,
  input wire logic t3_mode16_i,
  input wire logic external_convert_strobe_i,
  output logic [11:0] current_dac_zero_code_o,
  output logic [11:0] current_dac_one_code_o,
  output logic current_dac_zero_en_o,
  output logic current_dac_one_en_o,
  output logic [1:0] current_dac_zero_fs_o,
  output logic [1:0] current_dac_one_fs_o,
  output logic bias_req_o,
  output logic pin0_analog_o,
  output logic pin1_analog_o,
  output logic dac1_on_pin0_o
);
  localparam logic [1:0][7:0] CTRL_ADDR = {`IDACU_CTRL1_ADDR, `IDACU_CTRL0_ADDR};
  localparam logic [1:0][7:0] HIGH_ADDR = {`IDACU_HIGH1_ADDR, `IDACU_HIGH0_ADDR};
  localparam logic [1:0][7:0] LOW_ADDR = {`IDACU_LOW1_ADDR, `IDACU_LOW0_ADDR};

  idacu_pkg::idacu_top_st_t st;
  idacu_pkg::idacu_top_st_t nxt;
  logic [6:0] evt_common;
  logic strobe_rise;
  logic strobe_fall;
  logic [1:0][11:0] code_w;
  logic [1:0] pend_w;
  logic [1:0] en_w;
  logic [1:0] data_wr_w;

  idacu_chan_if ch_if[2] ();

  // the strobe is asynchronous, so edges are only seen on the second flop
  assign strobe_rise = st.sync2 & ~st.prev;
  assign strobe_fall = ~st.sync2 & st.prev;

  assign evt_common[0] = t0_ovf_i;
  assign evt_common[1] = t1_ovf_i;
  assign evt_common[2] = t2_mode16_i ? t2_high_ovf_i : t2_low_ovf_i;
  assign evt_common[3] = t3_mode16_i ? t3_high_ovf_i : t3_low_ovf_i;
  assign evt_common[4] = strobe_rise;
  assign evt_common[5] = strobe_fall;
  assign evt_common[6] = strobe_rise | strobe_fall;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      assign data_wr_w[g] = wr_i && (addr_i == HIGH_ADDR[g] || addr_i == LOW_ADDR[g]);
      assign ch_if[g].ctrl = st.ctrl[g];
      assign ch_if[g].hi = st.hi[g];
      assign ch_if[g].lo = st.lo[g];
      // on-demand fires the cycle after the high write, once both bytes are stored
      assign ch_if[g].evt = {st.hi_wr[g], evt_common};
      assign ch_if[g].wr_data = data_wr_w[g];
      assign code_w[g] = ch_if[g].code;
      assign pend_w[g] = ch_if[g].pend;
      assign en_w[g] = st.ctrl[g][`IDACU_EN_BIT];
      idacu_chan u_chan (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .ch(ch_if[g].chan)
      );
    end
  endgenerate

  always_comb begin
    nxt = st;
    nxt.rdata = '0;
    nxt.hi_wr = '0;
    nxt.sync1 = external_convert_strobe_i;
    nxt.sync2 = st.sync1;
    nxt.prev = st.sync2;
    if (wr_i) begin
      for (int n = 0; n < 2; n++) begin
        if (addr_i == CTRL_ADDR[n]) begin
          // reserved bit 3 is never stored and reads as zero
          nxt.ctrl[n] = wdata_i & `IDACU_CTRL_WMASK;
        end
        if (addr_i == HIGH_ADDR[n]) begin
          nxt.hi[n] = wdata_i;
          nxt.hi_wr[n] = 1'b1;
        end
        if (addr_i == LOW_ADDR[n]) begin
          // a low write only stores; the latch waits for its event
          nxt.lo[n] = wdata_i;
        end
      end
      if (addr_i == `IDACU_ROUTE_ADDR) begin
        nxt.merge = wdata_i[`IDACU_MERGE_BIT];
      end
    end
    if (rd_i) begin
      for (int n = 0; n < 2; n++) begin
        if (addr_i == CTRL_ADDR[n]) begin
          nxt.rdata = st.ctrl[n];
        end
        if (addr_i == HIGH_ADDR[n]) begin
          nxt.rdata = st.hi[n];
        end
        if (addr_i == LOW_ADDR[n]) begin
          nxt.rdata = st.lo[n];
        end
      end
      if (addr_i == `IDACU_ROUTE_ADDR) begin
        nxt.rdata = {st.merge, 7'h00};
      end
      if (addr_i == `IDACU_STATUS_ADDR) begin
        nxt.rdata = {3'h0, en_w, bias_req_o, pend_w};
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
      st.ctrl[0] <= `IDACU_CTRL_RST;
      st.ctrl[1] <= `IDACU_CTRL_RST;
      st.hi[0] <= `IDACU_DATA_RST;
      st.hi[1] <= `IDACU_DATA_RST;
      st.lo[0] <= `IDACU_DATA_RST;
      st.lo[1] <= `IDACU_DATA_RST;
      // the synchroniser keeps sampling so a pin held high gives no false edge after reset
      st.sync1 <= nxt.sync1;
      st.sync2 <= nxt.sync2;
      st.prev <= nxt.prev;
    end else begin
      st <= nxt;
    end
  end

  assign rdata_o = st.rdata;
  assign current_dac_zero_code_o = code_w[0];
  assign current_dac_one_code_o = code_w[1];
  assign current_dac_zero_en_o = en_w[0];
  assign current_dac_one_en_o = en_w[1];
  assign current_dac_zero_fs_o = st.ctrl[0][`IDACU_FS_HI:`IDACU_FS_LO];
  assign current_dac_one_fs_o = st.ctrl[1][`IDACU_FS_HI:`IDACU_FS_LO];
  assign bias_req_o = |en_w;
  // the second dac's pin follows merge select; merged pin carries both currents
  assign dac1_on_pin0_o = st.merge;
  assign pin0_analog_o = en_w[0] | (en_w[1] & st.merge);
  assign pin1_analog_o = en_w[1] & ~st.merge;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_RESET_SRC: assert property (
    $rose(resetn_i) |-> (st.ctrl[0] == `IDACU_CTRL_RST && st.ctrl[1] == `IDACU_CTRL_RST
                          && current_dac_zero_fs_o == 2'h3))
    else $error("control registers not at on-demand reset value");
  AST_ENABLE_WRITE: assert property (
    (wr_i && addr_i == `IDACU_CTRL1_ADDR) |=> current_dac_one_en_o == $past(wdata_i[7])
                                             && current_dac_zero_en_o == $past(current_dac_zero_en_o))
    else $error("enable bit not independent per dac");
  AST_FULL_SCALE: assert property (
    (wr_i && addr_i == `IDACU_CTRL0_ADDR) |=> current_dac_zero_fs_o == $past(wdata_i[1:0]))
    else $error("full-scale select not taken from bits 1:0");
  AST_BIAS: assert property (
    bias_req_o == (current_dac_zero_en_o || current_dac_one_en_o))
    else $error("bias request does not follow dac enables");
  AST_MERGED: assert property (
    (current_dac_zero_en_o && current_dac_one_en_o && st.merge)
      |-> (pin0_analog_o && !pin1_analog_o && dac1_on_pin0_o))
    else $error("merged outputs not on the first pin");
  AST_SEPARATE: assert property (
    (current_dac_zero_en_o && current_dac_one_en_o && !st.merge)
      |-> (pin0_analog_o && pin1_analog_o && !dac1_on_pin0_o))
    else $error("separate outputs not on two pins");
  AST_DEMAND_HIGH: assert property (
    (wr_i && addr_i == `IDACU_HIGH0_ADDR && st.ctrl[0][6:4] == 3'h7 && st.ctrl[0][2] == 1'b0)
      ##1 !wr_i |=> current_dac_zero_code_o == {$past(wdata_i, 2), st.lo[0][7:4]})
    else $error("high byte write did not update the dac on demand");
  AST_DEMAND_LOW_HELD: assert property (
    (wr_i && addr_i == `IDACU_LOW0_ADDR && st.ctrl[0][6:4] == 3'h7 && !st.hi_wr[0])
      |=> $stable(current_dac_zero_code_o))
    else $error("low byte write changed the dac output");
  AST_TIMER0: assert property (
    (st.ctrl[0][6:4] == 3'h0 && t0_ovf_i && !st.ctrl[0][2])
      |=> current_dac_zero_code_o == {$past(st.hi[0]), $past(st.lo[0][7:4])})
    else $error("timer 0 overflow did not copy held bytes");
  AST_TIMER2_WIDTH: assert property (
    (st.ctrl[0][6:4] == 3'h2 && !t2_mode16_i && t2_high_ovf_i && !t2_low_ovf_i)
      |=> $stable(current_dac_zero_code_o))
    else $error("8-bit timer 2 updated on the high overflow");
  AST_STROBE_SYNC: assert property (
    strobe_rise |-> ($past(external_convert_strobe_i, 2) && !$past(external_convert_strobe_i, 3)))
    else $error("strobe edge not seen after two flops");
  AST_STROBE_FALL_ONLY: assert property (
    (st.ctrl[1][6:4] == 3'h5 && strobe_fall && st.ctrl[1][2])
      |=> current_dac_one_code_o == {$past(st.hi[1][3:0]), $past(st.lo[1])})
    else $error("falling strobe edge did not copy held bytes");
  AST_STROBE_RISE_IGNORED: assert property (
    (st.ctrl[1][6:4] == 3'h5 && strobe_rise) |=> $stable(current_dac_one_code_o))
    else $error("rising strobe edge updated a falling-edge dac");
  AST_HELD_WRITE: assert property (
    (data_wr_w[0] && st.ctrl[0][6:4] != 3'h7) |=> pend_w[0])
    else $error("held data write not marked pending");

  COV_DEMAND: cover property (wr_i && addr_i == `IDACU_LOW0_ADDR ##[1:4] wr_i && addr_i == `IDACU_HIGH0_ADDR);
  COV_TIMER3: cover property (st.ctrl[0][6:4] == 3'h3 && t3_mode16_i && t3_high_ovf_i);
  COV_EITHER: cover property (st.ctrl[1][6:4] == 3'h6 && strobe_fall);
  COV_MERGE: cover property (pin0_analog_o && dac1_on_pin0_o && current_dac_zero_en_o);
  COV_FS_LOW: cover property (current_dac_one_fs_o == idacu_pkg::FS_QUARTER_MA && current_dac_one_en_o);
endmodule

// ---- pkg/idacu_chan_if.sv ----
// register side to channel side signals of one current dac
// assumes both ends run on sys_clk_i
`timescale 1ns/10ps
interface idacu_chan_if;
  logic [7:0] ctrl;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [7:0] evt;
  logic wr_data;
  logic [11:0] code;
  logic pend;
  modport regs (output ctrl, output hi, output lo, output evt, output wr_data, input code, input pend);
  modport chan (input ctrl, input hi, input lo, input evt, input wr_data, output code, output pend);
endinterface

// ---- pkg/idacu_pkg.sv ----
// types shared by the dual current dac update block
// assumes idacu_regs.svh is on the include path
package idacu_pkg;
  typedef enum logic [2:0] {SRC_TIMER0, SRC_TIMER1, SRC_TIMER2, SRC_TIMER3,
                            SRC_RISE, SRC_FALL, SRC_EITHER, SRC_DEMAND} idacu_src_t;
  typedef enum logic [1:0] {FS_QUARTER_MA, FS_HALF_MA, FS_ONE_MA, FS_TWO_MA} idacu_fs_t;
  typedef struct packed {
    logic [1:0][7:0] ctrl;
    logic [1:0][7:0] hi;
    logic [1:0][7:0] lo;
    logic merge;
    logic [7:0] rdata;
    logic [1:0] hi_wr;
    logic sync1;
    logic sync2;
    logic prev;
  } idacu_top_st_t;
  typedef struct packed {
    logic [11:0] code;
    logic pend;
  } idacu_chan_st_t;
endpackage

// ---- pkg/idacu_regs.svh ----
// register map, field positions and reset values of the dual current dac update block
// assumes an 8-bit special function register bus and 8-bit data registers
`ifndef IDACU_REGS_SVH
`define IDACU_REGS_SVH

`define IDACU_CTRL0_ADDR 8'hb9
`define IDACU_HIGH0_ADDR 8'h97
`define IDACU_LOW0_ADDR 8'h96
`define IDACU_CTRL1_ADDR 8'hb5
`define IDACU_HIGH1_ADDR 8'hf5
`define IDACU_LOW1_ADDR 8'hf4
`define IDACU_ROUTE_ADDR 8'h10
`define IDACU_STATUS_ADDR 8'h11

`define IDACU_EN_BIT 7
`define IDACU_SRC_HI 6
`define IDACU_SRC_LO 4
`define IDACU_RJ_BIT 2
`define IDACU_FS_HI 1
`define IDACU_FS_LO 0
`define IDACU_MERGE_BIT 7

`define IDACU_CTRL_RST 8'h73
`define IDACU_CTRL_WMASK 8'hf7
`define IDACU_DATA_RST 8'h00
`define IDACU_EVT_NUM 8

`endif

// ---- testbench/dual_current_dac_update_ctrl_tb_top.sv ----
// register-level bench of the dual current dac update block
// assumes idacu_regs.svh on the include path and the timer model beside it
`timescale 1ns/10ps
`include "idacu_regs.svh"
module dual_current_dac_update_ctrl_tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] fire = 6'h00;
  logic m2 = 1'b0;
  logic m3 = 1'b0;
  logic cstr = 1'b0;
  logic [5:0] ovf;
  logic [7:0] rdata, d;
  logic [7:0] hv = 8'h00;
  logic [11:0] code0, code1, cur, cur1;
  logic en0, en1, bias, pin0, pin1, on0;
  logic [1:0] fs0, fs1;
  int bad_count = 0;
  int n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  idacu_tmr_model tmr (.sys_clk_i(sys_clk), .resetn_i(resetn), .fire_i(fire), .ovf_o(ovf));
  idacu_top uut (.sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .t0_ovf_i(ovf[0]), .t1_ovf_i(ovf[1]), .t2_low_ovf_i(ovf[2]),
    .t2_high_ovf_i(ovf[3]), .t2_mode16_i(m2), .t3_low_ovf_i(ovf[4]), .t3_high_ovf_i(ovf[5]),
    .t3_mode16_i(m3), .external_convert_strobe_i(cstr), .current_dac_zero_code_o(code0),
    .current_dac_one_code_o(code1), .current_dac_zero_en_o(en0), .current_dac_one_en_o(en1),
    .current_dac_zero_fs_o(fs0), .current_dac_one_fs_o(fs1), .bias_req_o(bias),
    .pin0_analog_o(pin0), .pin1_analog_o(pin1), .dac1_on_pin0_o(on0));
  task automatic finish_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    v = rdata;
  endtask
  task automatic flags(input logic [5:0] exp);
    @(negedge sys_clk);
    chk("flags", {6'h00, en0, en1, bias, pin0, pin1, on0}, {6'h00, exp});
  endtask
  function automatic logic [11:0] word(input logic [7:0] h, input logic [7:0] l, input logic rj);
    return rj ? {h[3:0], l} : {h, l[7:4]};
  endfunction
  task automatic chk_code(input int ch, input logic [11:0] exp);
    cyc(3);
    @(negedge sys_clk);
    chk("code", ch ? code1 : code0, exp);
  endtask
  // low byte first, then high, as software must for a full word
  task automatic load(input int ch, input logic [7:0] h, input logic [7:0] l);
    wr_reg(ch ? `IDACU_LOW1_ADDR : `IDACU_LOW0_ADDR, l);
    wr_reg(ch ? `IDACU_HIGH1_ADDR : `IDACU_HIGH0_ADDR, h);
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    fire[i] <= 1'b1;
    @(posedge sys_clk);
    fire <= 6'h00;
  endtask
  task automatic edge_tst(input logic [2:0] s, input logic lvl, input logic upd);
    wr_reg(`IDACU_CTRL1_ADDR, {1'b1, s, 4'h4});
    hv = hv + 8'h11;
    load(1, hv, ~hv);
    chk_code(1, cur1);
    @(posedge sys_clk);
    cstr <= lvl;
    if (upd) cur1 = word(hv, ~hv, 1'b1);
    cyc(3);
    chk_code(1, cur1);
  endtask
  initial begin
    #100000;
    bad_count++;
    finish_test();
  end
  initial begin
    cyc(20);
    resetn <= 1'b1;
    rd_reg(`IDACU_CTRL0_ADDR, d);
    chk("ctrl0", {4'h0, d}, 12'h073);
    rd_reg(`IDACU_CTRL1_ADDR, d);
    chk("ctrl1", {4'h0, d}, 12'h073);
    rd_reg(8'h55, d);
    chk("unmapped", {4'h0, d}, 12'h000);
    chk("fs", {8'h00, fs0, fs1}, 12'h00f);
    wr_reg(`IDACU_CTRL0_ADDR, 8'hff);
    rd_reg(`IDACU_CTRL0_ADDR, d);
    chk("ctrl0 wr", {4'h0, d}, 12'h0f7);
    flags(6'b101100);
    wr_reg(`IDACU_CTRL1_ADDR, 8'hf0);
    flags(6'b111110);
    wr_reg(`IDACU_ROUTE_ADDR, 8'h80);
    flags(6'b111101);
    for (int k = 0; k < 4; k++) begin
      wr_reg(`IDACU_CTRL0_ADDR, {6'h3c, 2'(k)});
      @(negedge sys_clk);
      chk("fs0", {10'h000, fs0}, 12'(k));
    end
    wr_reg(`IDACU_ROUTE_ADDR, 8'h00);
    wr_reg(`IDACU_CTRL0_ADDR, 8'h70);
    wr_reg(`IDACU_CTRL1_ADDR, 8'h70);
    flags(6'b000000);
    wr_reg(`IDACU_LOW0_ADDR, 8'ha5);
    chk_code(0, 12'h000);
    wr_reg(`IDACU_HIGH0_ADDR, 8'h3c);
    chk_code(0, 12'h3ca);
    load(0, 8'h81, 8'h00);
    chk_code(0, 12'h810);
    wr_reg(`IDACU_HIGH0_ADDR, 8'h7e);
    chk_code(0, 12'h7e0);
    wr_reg(`IDACU_CTRL0_ADDR, 8'h74);
    load(0, 8'hf9, 8'h5a);
    cur = word(8'hf9, 8'h5a, 1'b1);
    chk_code(0, cur);
    // each timer source, with the neighbouring overflow fired first as a decoy
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      m2 <= (k >= 2) && (k % 2 == 1);
      m3 <= (k >= 2) && (k % 2 == 1);
      wr_reg(`IDACU_CTRL0_ADDR, {1'b0, 3'(k < 2 ? k : k / 2 + 1), 4'h0});
      hv = hv + 8'h11;
      load(0, hv, 8'hc0);
      chk_code(0, cur);
      pulse(k ^ 1);
      chk_code(0, cur);
      pulse(k);
      cur = word(hv, 8'hc0, 1'b0);
      chk_code(0, cur);
    end
    cur1 = 12'h000;
    edge_tst(3'h4, 1'b1, 1'b1);
    edge_tst(3'h4, 1'b0, 1'b0);
    edge_tst(3'h5, 1'b1, 1'b0);
    edge_tst(3'h5, 1'b0, 1'b1);
    edge_tst(3'h6, 1'b1, 1'b1);
    edge_tst(3'h6, 1'b0, 1'b1);
    finish_test();
  end
endmodule

// ---- testbench/idacu_tmr_model.sv ----
// timer side partner of the dac update block: six overflow pulse sources
// assumes requests come from the bench as one-cycle pulses on sys_clk_i
`timescale 1ns/10ps
module idacu_tmr_model (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [5:0] fire_i,
  output logic [5:0] ovf_o
);
  // order: t0, t1, t2 low, t2 high, t3 low, t3 high
  // registered so an overflow is one clean cycle, as a timer reload gives it
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ovf_o <= 6'h00;
    end else begin
      ovf_o <= fire_i;
    end
  end
endmodule
